// [design/dlc_pkg.sv]
package dlc_pkg;

  // Register byte offsets
  localparam logic [7:0] ADDR_CLOCK_SELECT_DIVIDE = 8'h71;
  localparam logic [7:0] ADDR_MULTIPLY_STATUS     = 8'h72;
  localparam logic [7:0] ADDR_RESTART             = 8'h75;
  localparam logic [7:0] ADDR_IRQ_STATUS          = 8'h80;
  localparam logic [7:0] ADDR_IRQ_MASK            = 8'h81;

  // Field positions in the clock select and divide register
  localparam int RX_SEL_BIT  = 7;
  localparam int TX_SEL_BIT  = 6;
  localparam int REF_EN_BIT  = 4;
  localparam int OUT_DIV_LSB = 0;
  localparam int OUT_DIV_W   = 4;

  // Field positions in the multiply and status register
  localparam int LOCK_BIT     = 7;
  localparam int POST_DIV_LSB = 5;
  localparam int POST_DIV_W   = 2;
  localparam int MULT_LSB     = 0;
  localparam int MULT_W       = 5;
  localparam int MP_W         = 7;

  // Field position in the restart register
  localparam int RESTART_BIT = 3;

  // Interrupt status and mask bits
  localparam int IRQ_LOCK_GAINED = 0;
  localparam int IRQ_LOCK_LOST   = 1;
  localparam int IRQ_RESTART     = 2;
  localparam int IRQ_BAD_DIVIDE  = 3;
  localparam int IRQ_STALE       = 4;
  localparam int IRQ_W           = 5;

  // Reset values
  localparam logic [7:0]       SEL_DIV_RESET     = 8'h01;
  localparam logic [MP_W-1:0]  MULT_POST_RESET   = 7'h00;
  localparam logic             RESTART_RESET     = 1'b0;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RESET    = 5'h00;
  localparam logic [3:0]       OUT_RATIO_RESET   = 4'h1;
  localparam logic [2:0]       POST_RATIO_RESET  = 3'h1;
  localparam logic [5:0]       MULT_FACTOR_RESET = 6'h01;

  // Reference edges counted before lock is reported
  localparam int LOCK_REF_EDGES = 64;

  typedef enum logic [2:0] {
    DLC_HELD    = 3'b001,
    DLC_ACQUIRE = 3'b010,
    DLC_LOCKED  = 3'b100
  } dlc_loop_state_t;

  // Output divide code: 1..6 and 8 are legal, ratio equals code
  function automatic logic dlc_div_valid(input logic [3:0] code);
    case (code)
      4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h8: dlc_div_valid = 1'b1;
      default:                                  dlc_div_valid = 1'b0;
    endcase
  endfunction : dlc_div_valid

  // Post divider ratio: 00 and 01 bypass
  function automatic logic [2:0] dlc_post_ratio(input logic [1:0] code);
    case (code)
      2'h2:    dlc_post_ratio = 3'h2;
      2'h3:    dlc_post_ratio = 3'h4;
      default: dlc_post_ratio = 3'h1;
    endcase
  endfunction : dlc_post_ratio

  // Multiplication factor is code plus one
  function automatic logic [5:0] dlc_mult_factor(input logic [4:0] code);
    dlc_mult_factor = {1'b0, code} + 6'h01;
  endfunction : dlc_mult_factor

endpackage : dlc_pkg

// [design/dlc_lock_timer.sv]
`timescale 1ns/10ps
module dlc_lock_timer #(
  parameter int EDGES = 64
) (
  input  wire logic i_clk,
  input  wire logic i_reset,
  input  wire logic i_clear,
  input  wire logic i_tick,
  output logic      o_done
);

  localparam int CW = $clog2(EDGES + 1);
  localparam logic [CW-1:0] LAST = CW'(EDGES - 1);

  typedef struct packed {
    logic [CW-1:0] count;
    logic          done;
  } dlc_timer_t;

  dlc_timer_t q;
  dlc_timer_t d;

  // Count qualifying reference edges; saturate once done
  always_comb begin
    d = q;
    if (i_clear) begin
      d = '0;
    end else if (i_tick && !q.done) begin
      if (q.count == LAST) begin
        d.done = 1'b1;
      end
      d.count = q.count + CW'(1);
    end
  end

  // State register
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign o_done = q.done;

endmodule : dlc_lock_timer

// [design/dlc_top.sv]
// Chosen here: the strobed register port.
`timescale 1ns/10ps
// Summary of operation
// RULE_01: Four-bit output divide code gives ratios 1..6 and 8; other codes invalid.
// RULE_02: Bit 7 of the multiply register reads one once the loop has locked.
// RULE_03: Post divider bits 6:5: 00/01 bypass, 10 divides by two, 11 by four.
// RULE_04: Multiply bits 4:0 set the factor to code plus one, 1 to 32.
// RULE_05: A zero-to-one edge on restart bit 3 restarts the loop; software supplies it.
// RULE_06: Software writes zero to all restart register bits except bit 3.
// RULE_07: Bit 7 picks the loop for the receive clock, bit 6 for transmit.
// RULE_08: Bit 4 gates the reference into the loop; cleared means no reference.
// RULE_09: Lock reads zero while held or after restart until lock is regained.
module dlc_top #(
  parameter int LOCK_REF_EDGES = dlc_pkg::LOCK_REF_EDGES
) (
  input  wire logic       i_clk,
  input  wire logic       i_reset,
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wr_data,
  input  wire logic       i_wr_en,
  input  wire logic       i_rd_en,
  input  wire logic       i_ref_clk,
  output logic      [7:0] o_rd_data,
  output logic            o_rx_clk_from_loop,
  output logic            o_tx_clk_from_loop,
  output logic            o_loop_ref_enable,
  output logic            o_loop_run,
  output logic            o_loop_restart,
  output logic      [3:0] o_out_divide_ratio,
  output logic            o_out_divide_valid,
  output logic      [2:0] o_post_divide_ratio,
  output logic      [5:0] o_mult_factor,
  output logic            o_loop_locked,
  output logic            o_irq
);

  // Every register of the block except the lock timer's in one packed struct
  typedef struct packed {
    logic [7:0]                  sel_div;
    logic [dlc_pkg::MP_W-1:0]    mult_post;
    logic                        restart_bit;
    dlc_pkg::dlc_loop_state_t    loop;
    logic                        ref_prev;
    logic [dlc_pkg::IRQ_W-1:0]   irq_status;
    logic [dlc_pkg::IRQ_W-1:0]   irq_mask;
    logic [7:0]                  rd_data;
    logic                        restart_pulse;
    logic [3:0]                  out_ratio;
    logic                        out_valid;
    logic [2:0]                  post_ratio;
    logic [5:0]                  mult;
  } dlc_state_t;

  // Registered copy and its next value
  dlc_state_t q;
  dlc_state_t d;

  // Decoded strobes and loop control terms
  logic                      wr_sel_div;
  logic                      wr_mult;
  logic                      wr_restart;
  logic                      wr_irq_mask;
  logic                      rd_irq_status;
  logic                      wr_div_ok;
  logic                      ref_rise;
  logic                      ref_gated;
  logic                      timer_clear;
  logic                      timer_tick;
  logic                      timer_done;
  logic                      restart_edge;
  logic                      settings_moved;
  logic [dlc_pkg::IRQ_W-1:0] events;
  logic [7:0]                rd_value;
  logic                      loop_locked;

  // Field pickers for the settings registers; the divide picker serves decode, compare and apply, the other two apply only
  function automatic logic [dlc_pkg::OUT_DIV_W-1:0] div_field(input logic [7:0] r);
    div_field = r[dlc_pkg::OUT_DIV_LSB +: dlc_pkg::OUT_DIV_W];
  endfunction : div_field

  // Post divider code out of the multiply register image
  function automatic logic [dlc_pkg::POST_DIV_W-1:0] post_field(
    input logic [dlc_pkg::MP_W-1:0] r
  );
    post_field = r[dlc_pkg::POST_DIV_LSB +: dlc_pkg::POST_DIV_W];
  endfunction : post_field

  // Multiplication code out of the multiply register image
  function automatic logic [dlc_pkg::MULT_W-1:0] mult_field(
    input logic [dlc_pkg::MP_W-1:0] r
  );
    mult_field = r[dlc_pkg::MULT_LSB +: dlc_pkg::MULT_W];
  endfunction : mult_field

  // Address decode; strobes never overlap so no arbitration
  assign wr_sel_div    = i_wr_en && (i_addr == dlc_pkg::ADDR_CLOCK_SELECT_DIVIDE);
  assign wr_mult       = i_wr_en && (i_addr == dlc_pkg::ADDR_MULTIPLY_STATUS);
  assign wr_restart    = i_wr_en && (i_addr == dlc_pkg::ADDR_RESTART);
  assign wr_irq_mask   = i_wr_en && (i_addr == dlc_pkg::ADDR_IRQ_MASK);
  assign rd_irq_status = i_rd_en && (i_addr == dlc_pkg::ADDR_IRQ_STATUS);

  // Validity of a divide code being written now
  // Flagged at write time so software hears of it before any restart
  assign wr_div_ok = dlc_pkg::dlc_div_valid(
    div_field(i_wr_data)); // RULE_01

  // Restart is edge triggered: rewriting one while already one does nothing
  assign restart_edge = wr_restart && i_wr_data[dlc_pkg::RESTART_BIT]
                        && !q.restart_bit; // RULE_05

  // Reference pin is synchronous; rising edges only reach the loop when gated on
  // Previous level resets low; harmless, as the loop is held after reset
  assign ref_rise  = i_ref_clk && !q.ref_prev;
  assign ref_gated = q.sel_div[dlc_pkg::REF_EN_BIT]; // RULE_08

  // Loop only progresses toward lock with a reference and a legal divide
  assign timer_tick  = ref_rise && ref_gated && q.out_valid; // RULE_08
  assign timer_clear = (q.loop != dlc_pkg::DLC_ACQUIRE); // RULE_09

  // Loop settings edited after a restart are not applied until the next one
  // Nothing is latched here; the stale event only tells software to restart
  always_comb begin
    settings_moved = 1'b0;
    if (q.loop != dlc_pkg::DLC_HELD) begin
      if (wr_sel_div
          && (div_field(i_wr_data) != div_field(q.sel_div))) begin
        settings_moved = 1'b1;
      end
      if (wr_mult && (i_wr_data[dlc_pkg::MP_W-1:0] != q.mult_post)) begin
        settings_moved = 1'b1;
      end
    end
  end

  // Lock flag decoded once for the status read and the pin
  assign loop_locked = (q.loop == dlc_pkg::DLC_LOCKED); // RULE_02

  // Read multiplexer; unmapped offsets read as zero
  // Status reads show the value from before their own clear
  always_comb begin
    case (i_addr)
      dlc_pkg::ADDR_CLOCK_SELECT_DIVIDE: begin
        rd_value = q.sel_div;
      end
      dlc_pkg::ADDR_MULTIPLY_STATUS: begin
        rd_value = {loop_locked, q.mult_post}; // RULE_02
      end
      dlc_pkg::ADDR_RESTART: begin
        rd_value = {4'h0, q.restart_bit, 3'h0}; // RULE_06
      end
      dlc_pkg::ADDR_IRQ_STATUS: begin
        rd_value = {3'h0, q.irq_status};
      end
      dlc_pkg::ADDR_IRQ_MASK: begin
        rd_value = {3'h0, q.irq_mask};
      end
      default: begin
        rd_value = 8'h00;
      end
    endcase
  end

  // Next state of the whole block
  // Defaults hold every register but ref_prev, which samples the reference pin; pulses and read data fall back to zero
  always_comb begin
    d                = q;
    events           = '0;
    d.restart_pulse  = 1'b0;
    d.ref_prev       = i_ref_clk;
    d.rd_data        = i_rd_en ? rd_value : 8'h00;

    // Clock select, reference gate and output divide code
    if (wr_sel_div) begin
      d.sel_div = i_wr_data; // RULE_07
      if (!wr_div_ok) begin
        events[dlc_pkg::IRQ_BAD_DIVIDE] = 1'b1; // RULE_01
      end
    end

    // Lock bit is read only; only the low seven bits take the write
    // Writes while the loop runs are stored but not applied; a changed value raises the stale event
    if (wr_mult) begin
      d.mult_post = i_wr_data[dlc_pkg::MP_W-1:0]; // RULE_02
    end

    // Only the restart bit is kept; the other bits are expected zero
    if (wr_restart) begin
      d.restart_bit = i_wr_data[dlc_pkg::RESTART_BIT]; // RULE_06
    end

    // Mask register, same layout as status
    if (wr_irq_mask) begin
      d.irq_mask = i_wr_data[dlc_pkg::IRQ_W-1:0];
    end

    // Latch loop settings at the restart edge
    // An invalid divide is applied as ratio zero and blocks lock
    if (restart_edge) begin
      d.restart_pulse = 1'b1; // RULE_05
      events[dlc_pkg::IRQ_RESTART] = 1'b1;
      d.out_valid  = dlc_pkg::dlc_div_valid(
        div_field(q.sel_div)); // RULE_01
      d.out_ratio  = d.out_valid ?
        div_field(q.sel_div) : 4'h0; // RULE_01
      d.post_ratio = dlc_pkg::dlc_post_ratio(
        post_field(q.mult_post)); // RULE_03
      d.mult       = dlc_pkg::dlc_mult_factor(
        mult_field(q.mult_post)); // RULE_04
    end

    // Stale settings event
    if (settings_moved) begin
      events[dlc_pkg::IRQ_STALE] = 1'b1;
    end

    // Loop state: held while the restart bit is low
    case (q.loop)
      dlc_pkg::DLC_HELD: begin
        // Only a fresh edge leaves hold; rewriting a one does nothing
        if (restart_edge) begin
          d.loop = dlc_pkg::DLC_ACQUIRE; // RULE_05
        end
      end
      dlc_pkg::DLC_ACQUIRE: begin
        if (!d.restart_bit) begin
          d.loop = dlc_pkg::DLC_HELD; // RULE_09
        end else if (timer_done && ref_gated) begin // RULE_08
          // Reference must still be gated when lock is declared
          d.loop = dlc_pkg::DLC_LOCKED; // RULE_02
          events[dlc_pkg::IRQ_LOCK_GAINED] = 1'b1;
        end
      end
      dlc_pkg::DLC_LOCKED: begin
        // Dropping the run bit wins over a lost reference
        if (!d.restart_bit) begin
          d.loop = dlc_pkg::DLC_HELD; // RULE_09
          events[dlc_pkg::IRQ_LOCK_LOST] = 1'b1;
        end else if (!ref_gated) begin
          // Losing the reference drops lock; it is regained on return
          d.loop = dlc_pkg::DLC_ACQUIRE; // RULE_08
          events[dlc_pkg::IRQ_LOCK_LOST] = 1'b1;
        end
      end
      default: begin
        d.loop = dlc_pkg::DLC_HELD;
      end
    endcase

    // Read clears status, but a same-cycle event still lands
    // Events are one-cycle strobes gathered above
    d.irq_status = (rd_irq_status ? '0 : q.irq_status) | events;
  end

  // State register
  // Synchronous reset; the divide code resets legal so a first restart can lock
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      q               <= '0;
      q.sel_div       <= dlc_pkg::SEL_DIV_RESET;
      q.mult_post     <= dlc_pkg::MULT_POST_RESET;
      q.restart_bit   <= dlc_pkg::RESTART_RESET;
      q.loop          <= dlc_pkg::DLC_HELD;
      q.irq_mask      <= dlc_pkg::IRQ_MASK_RESET;
      q.out_ratio     <= dlc_pkg::OUT_RATIO_RESET;
      q.out_valid     <= 1'b1;
      q.post_ratio    <= dlc_pkg::POST_RATIO_RESET;
      q.mult          <= dlc_pkg::MULT_FACTOR_RESET;
    end else begin
      q <= d;
    end
  end

  // Lock acquisition time measured in gated reference edges
  // Cleared outside acquisition, so every attempt counts from zero
  dlc_lock_timer #(
    .EDGES (LOCK_REF_EDGES)
  ) u_lock_timer (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .i_clear (timer_clear),
    .i_tick  (timer_tick),
    .o_done  (timer_done)
  );

  // Outputs, all straight from flops except the decoded lock flag and interrupt
  assign o_rd_data           = q.rd_data;
  assign o_rx_clk_from_loop  = q.sel_div[dlc_pkg::RX_SEL_BIT]; // RULE_07
  assign o_tx_clk_from_loop  = q.sel_div[dlc_pkg::TX_SEL_BIT]; // RULE_07
  assign o_loop_ref_enable   = ref_gated; // RULE_08

  // Loop run level and one-cycle restart pulse
  assign o_loop_run          = q.restart_bit; // RULE_05
  assign o_loop_restart      = q.restart_pulse; // RULE_05

  // Applied ratios stand until the next restart edge
  assign o_out_divide_ratio  = q.out_ratio;
  assign o_out_divide_valid  = q.out_valid;
  assign o_post_divide_ratio = q.post_ratio;
  assign o_mult_factor       = q.mult;

  // Lock flag and level interrupt
  assign o_loop_locked       = loop_locked; // RULE_09
  assign o_irq               = |(q.irq_status & q.irq_mask);

endmodule : dlc_top

// [tb/dlc_top_asserts.sv]
`timescale 1ns/10ps
module dlc_top_asserts (
  input wire logic       i_clk,
  input wire logic       i_reset,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wr_data,
  input wire logic       i_wr_en,
  input wire logic       i_rd_en,
  input wire logic [7:0] o_rd_data,
  input wire logic       o_rx_clk_from_loop,
  input wire logic       o_tx_clk_from_loop,
  input wire logic       o_loop_ref_enable,
  input wire logic       o_loop_run,
  input wire logic       o_loop_restart,
  input wire logic [3:0] o_out_divide_ratio,
  input wire logic       o_out_divide_valid,
  input wire logic [2:0] o_post_divide_ratio,
  input wire logic [5:0] o_mult_factor,
  input wire logic       o_loop_locked
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  logic [3:0] div_q;
  logic [6:0] mp_q;
  logic       dv;
  // Shadow of the settings, so applied values can be judged at the restart edge
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      div_q <= 4'h1;
      mp_q  <= 7'h00;
    end else if (i_wr_en && i_addr == dlc_pkg::ADDR_CLOCK_SELECT_DIVIDE) begin
      div_q <= i_wr_data[3:0];
    end else if (i_wr_en && i_addr == dlc_pkg::ADDR_MULTIPLY_STATUS) begin
      mp_q <= i_wr_data[6:0];
    end
  end
  assign dv = div_q inside {4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h8};
  // Guards on $past keep a mid-run reset from comparing across it
  chk_rd_idle: assert property (!$past(i_reset) && !$past(i_rd_en) |-> o_rd_data == 8'h00)
    else $error("read data not idle");
  chk_lock_flag: assert property (!$past(i_reset) && $past(i_rd_en && i_addr == 8'h72)
    |-> o_rd_data[7] == $past(o_loop_locked)) else $error("lock flag read wrong");
  chk_post_apply: assert property (o_loop_restart |-> o_post_divide_ratio ==
    (mp_q[6:5] == 2'h3 ? 3'h4 : (mp_q[6:5] == 2'h2 ? 3'h2 : 3'h1))) else $error("post bad");
  chk_mult_apply: assert property (o_loop_restart |->
    o_mult_factor == ({1'b0, mp_q[4:0]} + 6'h01)) else $error("mult factor bad");
  chk_div_apply: assert property (o_loop_restart |-> o_out_divide_valid == dv &&
    o_out_divide_ratio == (dv ? div_q : 4'h0)) else $error("divide bad");
  chk_ratio_hold: assert property (!$past(i_reset) && !o_loop_restart |->
    $stable(o_mult_factor) && $stable(o_out_divide_ratio) && $stable(o_post_divide_ratio))
    else $error("ratio moved without restart");
  chk_restart_edge: assert property (i_wr_en && i_addr == 8'h75 |=>
    o_loop_run == $past(i_wr_data[3]) && o_loop_restart == ($past(i_wr_data[3]) &&
    !$past(o_loop_run)) ##1 !o_loop_restart) else $error("restart edge wrong");
  chk_sel_follow: assert property (i_wr_en && i_addr == 8'h71 |=>
    {o_rx_clk_from_loop, o_tx_clk_from_loop} == $past(i_wr_data[7:6])) else $error("sel");
  chk_ref_gate: assert property (i_wr_en && i_addr == 8'h71 |=>
    o_loop_ref_enable == $past(i_wr_data[4])) else $error("ref gate");
  chk_lock_held: assert property (!o_loop_run || o_loop_restart |-> !o_loop_locked)
    else $error("locked while held");
  chk_lock_cause: assert property ($rose(o_loop_locked) |->
    $past(o_loop_ref_enable) && o_out_divide_valid) else $error("lock without ref");
endmodule : dlc_top_asserts
bind dlc_top dlc_top_asserts u_dlc_top_asserts (.*);

// [tb/dlc_top_tb_top.sv]
`timescale 1ns/10ps
module dlc_top_tb_top;
  logic       i_clk, i_reset, i_wr_en, i_rd_en, i_ref_clk;
  logic [7:0] i_addr, i_wr_data, o_rd_data;
  logic       o_rx_clk_from_loop, o_tx_clk_from_loop, o_loop_ref_enable, o_loop_run;
  logic       o_loop_restart, o_out_divide_valid, o_loop_locked, o_irq;
  logic [3:0] o_out_divide_ratio;
  logic [2:0] o_post_divide_ratio;
  logic [5:0] o_mult_factor;
  logic [1:0] ref_cnt = 2'h0;
  int         error_cnt = 0;
  int         compares = 0;
  // Short lock count keeps each acquisition near sixteen cycles
  dlc_top #(.LOCK_REF_EDGES(4)) u_dlc_top (.*);
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  // Reference at a quarter of the system clock, free running
  always @(posedge i_clk) ref_cnt <= ref_cnt + 2'h1;
  assign i_ref_clk = ref_cnt[1];
  task automatic check(input logic ok, input string msg);
    compares++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("unexpected %0t %s", $time, msg);
    end
  endtask : check
  // Strobe for one cycle, then look just after the edge that took it
  task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr_en   <= wr;
    i_rd_en   <= ~wr;
    i_addr    <= a;
    i_wr_data <= d;
    @(posedge i_clk);
    i_wr_en <= 1'b0;
    i_rd_en <= 1'b0;
    #1;
  endtask : access
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    access(1'b0, a, 8'h00);
    check(o_rd_data === exp, $sformatf("read %h gave %h", a, o_rd_data));
  endtask : rd
  task automatic t_reset;
    rd(8'h71, 8'h01);
    rd(8'h72, 8'h00);
    rd(8'h75, 8'h00);
    rd(8'h81, 8'h00);
    rd(8'h90, 8'h00);
    check({o_mult_factor, o_post_divide_ratio, o_out_divide_ratio} === 13'h0091, "reset");
    check({o_loop_run, o_loop_locked, o_irq, o_loop_ref_enable} === 4'h0, "idle");
  endtask : t_reset
  task automatic t_select;
    access(1'b1, 8'h71, 8'hf3);
    check({o_rx_clk_from_loop, o_tx_clk_from_loop, o_loop_ref_enable} === 3'h7, "sel");
    rd(8'h71, 8'hf3);
    access(1'b1, 8'h71, 8'h14);
    check({o_rx_clk_from_loop, o_tx_clk_from_loop} === 2'h0, "sel clear");
  endtask : t_select
  task automatic wait_lock;
    int n;
    n = 0;
    while (o_loop_locked !== 1'b1 && n < 60) begin
      @(posedge i_clk);
      #1;
      n++;
    end
    check(o_loop_locked === 1'b1, "no lock");
  endtask : wait_lock
  task automatic t_lock;
    access(1'b1, 8'h81, 8'h01);
    access(1'b1, 8'h72, 8'hff);
    rd(8'h72, 8'h7f);
    access(1'b1, 8'h75, 8'h08);
    check({o_loop_restart, o_loop_run, o_loop_locked} === 3'h6, "restart");
    check({o_mult_factor, o_post_divide_ratio} === 9'h104, "applied");
    wait_lock();
    rd(8'h72, 8'hff);
    check(o_irq === 1'b1, "irq not raised");
    rd(8'h80, 8'h05);
    check(o_irq === 1'b0, "irq not cleared");
    access(1'b1, 8'h72, 8'h40);
    access(1'b1, 8'h75, 8'h08);
    check(o_loop_restart === 1'b0 && o_mult_factor === 6'h20, "no edge");
    access(1'b1, 8'h71, 8'h04);
    @(posedge i_clk);
    #1;
    check(o_loop_locked === 1'b0, "lock kept without ref");
    access(1'b1, 8'h75, 8'h00);
    check({o_loop_run, o_loop_locked} === 2'h0, "hold");
    access(1'b1, 8'h75, 8'h08);
    check({o_mult_factor, o_post_divide_ratio} === 9'h00a, "reapplied");
  endtask : t_lock
  task automatic t_div;
    logic ok;
    access(1'b1, 8'h72, 8'h3f);
    for (int c = 0; c < 16; c++) begin
      ok = c inside {1, 2, 3, 4, 5, 6, 8};
      access(1'b1, 8'h75, 8'h00);
      access(1'b1, 8'h71, 8'h10 | 8'(c));
      access(1'b1, 8'h75, 8'h08);
      check(o_out_divide_valid === ok && o_out_divide_ratio === (ok ? 4'(c) : 4'h0), "div");
    end
    repeat (60) @(posedge i_clk);
    #1;
    check(o_loop_locked === 1'b0, "locked on bad divide");
    check({o_mult_factor, o_post_divide_ratio} === 9'h101, "bypass post");
    rd(8'h80, 8'h1e);
  endtask : t_div
  task automatic finish_test;
    if (error_cnt == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : finish_test
  initial begin
    repeat (5000) @(posedge i_clk);
    error_cnt++;
    finish_test();
  end
  initial begin
    i_reset   = 1'b1;
    i_wr_en   = 1'b0;
    i_rd_en   = 1'b0;
    i_addr    = 8'h00;
    i_wr_data = 8'h00;
    repeat (8) @(posedge i_clk);
    i_reset <= 1'b0;
    t_reset();
    t_select();
    t_lock();
    t_div();
    finish_test();
  end
endmodule : dlc_top_tb_top
